// ==== design/uhd_uart.sv ====
// Full/half-duplex serial transceiver with byte register port
`timescale 1ns/100ps
`include "uhd_map.svh"
module uhd_uart (
  input  wire logic       clk_i,            // System clock, 250 MHz
  input  wire logic       sys_rst_i,        // Asynchronous reset, active high
  input  wire logic [3:0] reg_sel_i,        // Register index
  input  wire logic       reg_wr_i,         // Register write strobe
  input  wire logic       reg_rd_i,         // Register read strobe
  input  wire logic [7:0] reg_wdata_i,      // Write data
  output logic      [7:0] reg_rdata_o,      // Read data, one cycle after strobe
  input  wire logic       rxtx_pin_i,       // Shared pin level
  output logic            rxtx_pin_o,       // Shared pin drive value
  output logic            rxtx_pin_oe_o,    // Shared pin drive enable
  output logic            tx_pin_o,         // Transmit pin drive value
  output logic            tx_pin_oe_o,      // Transmit pin drive enable
  input  wire logic       gpio_pu_tx_i,     // GPIO pull-up setting, transmit pin
  input  wire logic       gpio_pu_rxtx_i,   // GPIO pull-up setting, shared pin
  output logic            tx_pullup_en_o,   // Pull-up connect, transmit pin
  output logic            rxtx_pullup_en_o, // Pull-up connect, shared pin
  output logic            irq_o,            // Interrupt request level
  output logic            wake_o            // Wake-up pulse
);
  import uhd_pkg::*;

  // Software registers
  logic [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q, div_hi_q, div_lo_q, fifo_ctrl_q;
  // Sticky error flags
  logic       parity_error_flag_q, nf_q, framing_fault_flag_q, overrun_flag_q;
  // Derived status flags, registered
  logic       rx_data_ready_q, tx_done_flag_q, tx_buffer_empty_q, rx_idle_flag_q;
  // Status-read armed for clear sequence
  logic       arm_q;
  // Address-detect event, held until data read
  logic       addr_q;
  // Pin synchroniser and sample history
  logic       rx_m_q, rx_s_q, rx_p_q;
  logic [2:0] hist_q;

  // Control field decode
  wire        serial_on   = ctrl_a_q[`UHD_A_SERIAL_ON];
  wire        nine_bit    = ctrl_a_q[`UHD_A_NINE_BIT];
  wire        parity_en   = ctrl_a_q[`UHD_A_PARITY_EN];
  wire [1:0]  parity_type = ctrl_a_q[`UHD_A_PARITY_HI:`UHD_A_PARITY_LO];
  wire        tx_break    = ctrl_a_q[`UHD_A_TX_BREAK];
  wire        tx_enable   = ctrl_b_q[`UHD_B_TX_ENABLE];
  wire        rx_enable   = ctrl_b_q[`UHD_B_RX_ENABLE];
  wire        two_stop    = ctrl_b_q[`UHD_B_TWO_STOP];
  wire        single_wire_select = ctrl_c_q[`UHD_C_SINGLE_WIRE];
  wire        tx_mirror   = ctrl_c_q[`UHD_C_TX_MIRROR];

  // Baud divisor from the two byte registers, zero treated as one
  wire [15:0] div_raw  = {div_hi_q, div_lo_q};
  wire [15:0] div_m1   = (div_raw == 16'h0000) ? 16'h0000 : div_raw - 16'h0001;
  wire [15:0] div_half = {1'b0, div_m1[15:1]};
  wire [3:0]  nbits    = nine_bit ? 4'h9 : 4'h8;

  // Pin roles: receive priority in single-wire mode
  wire        rx_run   = serial_on & rx_enable;
  wire        tx_run   = serial_on & tx_enable & ~(single_wire_select & rx_enable);
  wire        sw_drive = single_wire_select & tx_run;
  wire        tx_drive = tx_run & (~single_wire_select | tx_mirror);

  // Register port decode
  wire sel_stat = reg_sel_i == `UHD_IDX_STATUS_FLAGS;
  wire sel_ca   = reg_sel_i == `UHD_IDX_UART_CTRL_A;
  wire sel_cb   = reg_sel_i == `UHD_IDX_UART_CTRL_B;
  wire sel_cc   = reg_sel_i == `UHD_IDX_UART_CTRL_C;
  wire sel_data = reg_sel_i == `UHD_IDX_DATA_PORT;
  wire sel_dh   = reg_sel_i == `UHD_IDX_BAUD_DIV_HIGH;
  wire sel_dl   = reg_sel_i == `UHD_IDX_BAUD_DIV_LOW;
  wire sel_fc   = reg_sel_i == `UHD_IDX_FIFO_CTRL;
  wire sel_cnt  = reg_sel_i == `UHD_IDX_RX_FILL_COUNT;
  wire stat_rd  = reg_rd_i & sel_stat;
  wire data_rd  = reg_rd_i & sel_data;
  wire data_wr  = reg_wr_i & sel_data;
  wire clr_seq  = arm_q & (data_rd | data_wr);

  // ---------------- Receive FIFO ----------------
  uhd_char_t  fifo_mem [0:3];       // Four received characters
  logic [1:0] fifo_wp_q, fifo_rp_q; // Write and read pointers
  logic [2:0] fifo_cnt_q;           // Fill count 0..4
  logic       rx_push;              // Store a completed character
  uhd_char_t  rx_word;              // Character being stored
  wire        fifo_full  = fifo_cnt_q == 3'h4;
  wire        fifo_pop   = data_rd & (fifo_cnt_q != 3'h0);
  wire [2:0]  fifo_cnt_d = fifo_cnt_q + {2'b00, rx_push} - {2'b00, fifo_pop};
  wire [2:0]  trig_lvl   = {1'b0, fifo_ctrl_q[1:0]} + 3'h1;
  uhd_char_t  fifo_head;
  assign fifo_head = fifo_mem[fifo_rp_q];

  // FIFO storage and pointers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fifo_wp_q  <= 2'h0;
      fifo_rp_q  <= 2'h0;
      fifo_cnt_q <= 3'h0;
    end else begin
      if (rx_push) begin
        fifo_mem[fifo_wp_q] <= rx_word;
        fifo_wp_q <= fifo_wp_q + 2'h1;
      end
      if (fifo_pop) begin
        fifo_rp_q <= fifo_rp_q + 2'h1;
      end
      fifo_cnt_q <= fifo_cnt_d;
    end
  end

  // ---------------- Receiver ----------------
  uhd_rx_state_t rx_st_q;
  logic [15:0]   rcnt_q;      // Bit timer
  logic [3:0]    rbit_q;      // Data bit index
  uhd_char_t     rsh_q;       // Receive shift register
  logic          rnoise_q;    // Noise seen in this frame
  logic          rperr_q;     // Parity mismatch in this frame
  wire maj   = (hist_q[0] & hist_q[1]) | (hist_q[0] & hist_q[2]) | (hist_q[1] & hist_q[2]);
  wire noisy = ~((hist_q == 3'b000) | (hist_q == 3'b111));
  wire r_tgt_hit = (rx_st_q == UHD_R_START) ? (rcnt_q == div_half) : (rcnt_q == div_m1);
  wire fall  = rx_p_q & ~rx_s_q;
  // Parity expected over received data bits; eight-bit data sits in the upper bits
  wire rdata_par = nine_bit ? ^rsh_q : ^rsh_q[8:1];
  wire r_par_exp = (parity_type == 2'b00) ? rdata_par :
                   (parity_type == 2'b01) ? ~rdata_par : ~parity_type[0];
  // Character aligned LSB first, nine-bit or eight-bit
  wire [8:0]  r_final = nine_bit ? rsh_q : {1'b0, rsh_q[8:1]};
  wire last_bit = nine_bit ? rsh_q[8] : rsh_q[8];
  wire r_stop_now = (rx_st_q == UHD_R_STOP) & r_tgt_hit;
  wire r_store    = r_stop_now & ~overrun_flag_q & ~fifo_full;
  assign rx_push = r_store;
  assign rx_word = r_final;

  // Pin synchroniser and majority history
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
      hist_q <= 3'b111;
    end else begin
      rx_m_q <= rxtx_pin_i;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
      hist_q <= {hist_q[1:0], rx_s_q};
    end
  end

  // Receive state machine
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st_q  <= UHD_R_IDLE;
      rcnt_q   <= 16'h0000;
      rbit_q   <= 4'h0;
      rsh_q    <= 9'h000;
      rnoise_q <= 1'b0;
      rperr_q  <= 1'b0;
    end else if (!rx_run) begin
      rx_st_q <= UHD_R_IDLE;
    end else begin
      rcnt_q <= r_tgt_hit ? 16'h0000 : rcnt_q + 16'h0001;
      case (rx_st_q)
        UHD_R_IDLE: begin
          rcnt_q <= 16'h0000;
          if (fall) begin // Start bit edge
            rx_st_q  <= UHD_R_START;
            rnoise_q <= 1'b0;
            rperr_q  <= 1'b0;
            rbit_q   <= 4'h0;
          end
        end
        UHD_R_START: begin
          if (r_tgt_hit) begin
            rnoise_q <= noisy;
            rx_st_q  <= maj ? UHD_R_IDLE : UHD_R_DATA; // False start rejected
          end
        end
        UHD_R_DATA: begin
          if (r_tgt_hit) begin
            rsh_q    <= {maj, rsh_q[8:1]};
            rnoise_q <= rnoise_q | noisy;
            rbit_q   <= rbit_q + 4'h1;
            if (rbit_q == nbits - 4'h1) begin
              rx_st_q <= parity_en ? UHD_R_PAR : UHD_R_STOP;
            end
          end
        end
        UHD_R_PAR: begin
          if (r_tgt_hit) begin
            rperr_q  <= maj ^ r_par_exp;
            rnoise_q <= rnoise_q | noisy;
            rx_st_q  <= UHD_R_STOP;
          end
        end
        default: begin
          if (r_tgt_hit) begin
            rx_st_q <= UHD_R_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- Transmitter ----------------
  uhd_tx_state_t tx_st_q;
  logic [15:0]   tcnt_q;      // Bit timer
  logic [3:0]    tbit_q;      // Bit index within state
  uhd_char_t     tsh_q;       // Transmit shift register
  logic          tpar_q;      // Parity bit to send
  logic          tline_q;     // Serial line level
  uhd_char_t     tbuf_q;      // One-character transmit buffer
  logic          tbuf_v_q;    // Buffer holds a character
  logic          ten_p_q;     // Transmit enable last cycle
  wire t_tick  = tcnt_q == div_m1;
  wire tx_en_rise = tx_enable & ~ten_p_q;
  wire t_load  = (tx_st_q == UHD_T_IDLE) & tx_run & tbuf_v_q & ~tx_break & ~tx_en_rise;
  wire tbuf_par = nine_bit ? ^tbuf_q : ^tbuf_q[7:0];
  wire t_par_v = (parity_type == 2'b00) ? tbuf_par :
                 (parity_type == 2'b01) ? ~tbuf_par : ~parity_type[0];
  wire [3:0] t_stop_n = two_stop ? 4'h2 : 4'h1;

  // Transmit buffer fill from data port writes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tbuf_q   <= 9'h000;
      tbuf_v_q <= 1'b0;
      ten_p_q  <= 1'b0;
    end else begin
      ten_p_q <= tx_enable;
      if (tx_en_rise) begin
        tbuf_v_q <= 1'b0;
      end else if (data_wr) begin
        tbuf_q   <= {ctrl_a_q[`UHD_A_TX_BIT8], reg_wdata_i};
        tbuf_v_q <= 1'b1;
      end else if (t_load) begin
        tbuf_v_q <= 1'b0;
      end
    end
  end

  // Transmit state machine
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st_q <= UHD_T_IDLE;
      tcnt_q  <= 16'h0000;
      tbit_q  <= 4'h0;
      tsh_q   <= 9'h000;
      tpar_q  <= 1'b0;
      tline_q <= 1'b1;
    end else if (!tx_run) begin
      tx_st_q <= UHD_T_IDLE;
      tline_q <= 1'b1;
    end else begin
      tcnt_q <= t_tick ? 16'h0000 : tcnt_q + 16'h0001;
      case (tx_st_q)
        UHD_T_IDLE: begin
          tcnt_q <= 16'h0000;
          tbit_q <= 4'h0;
          if (tx_break) begin
            tx_st_q <= UHD_T_BREAK;
            tline_q <= 1'b0;
          end else if (t_load) begin
            tsh_q   <= tbuf_q;
            tpar_q  <= t_par_v;
            tx_st_q <= UHD_T_START;
            tline_q <= 1'b0;
          end
        end
        UHD_T_START: begin
          if (t_tick) begin
            tx_st_q <= UHD_T_DATA;
            tline_q <= tsh_q[0];
            tsh_q   <= {1'b0, tsh_q[8:1]};
          end
        end
        UHD_T_DATA: begin
          if (t_tick) begin
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == nbits - 4'h1) begin
              tbit_q  <= 4'h0;
              tx_st_q <= parity_en ? UHD_T_PAR : UHD_T_STOP;
              tline_q <= parity_en ? tpar_q : 1'b1;
            end else begin
              tline_q <= tsh_q[0];
              tsh_q   <= {1'b0, tsh_q[8:1]};
            end
          end
        end
        UHD_T_PAR: begin
          if (t_tick) begin
            tx_st_q <= UHD_T_STOP;
            tline_q <= 1'b1;
          end
        end
        UHD_T_BREAK: begin
          if (t_tick) begin
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == `UHD_BREAK_BITS - 4'h1) begin
              tbit_q  <= 4'h0;
              tx_st_q <= UHD_T_STOP;
              tline_q <= 1'b1;
            end
          end
        end
        default: begin
          if (t_tick) begin
            tbit_q <= tbit_q + 4'h1;
            if (tbit_q == t_stop_n - 4'h1) begin
              tx_st_q <= UHD_T_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ---------------- Status flags ----------------
  wire addr_hit = r_store & ctrl_b_q[`UHD_B_ADDR_EN] & last_bit;
  wire tx_done_flag_d  = ~tbuf_v_q & ~tx_break & (tx_st_q == UHD_T_IDLE);

  // Flag updates; hardware set wins over software clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parity_error_flag_q  <= 1'b0;
      nf_q    <= 1'b0;
      framing_fault_flag_q  <= 1'b0;
      overrun_flag_q  <= 1'b0;
      rx_idle_flag_q <= 1'b1;
      rx_data_ready_q  <= 1'b0;
      tx_done_flag_q <= 1'b1;
      tx_buffer_empty_q  <= 1'b1;
      arm_q   <= 1'b0;
      addr_q  <= 1'b0;
    end else begin
      parity_error_flag_q  <= (r_store & parity_en & rperr_q) | (parity_error_flag_q & ~clr_seq);
      nf_q    <= (r_store & rnoise_q) | (nf_q & ~clr_seq);
      framing_fault_flag_q  <= (r_store & ~maj) | (framing_fault_flag_q & ~clr_seq);
      overrun_flag_q  <= (r_stop_now & fifo_full) | (overrun_flag_q & ~clr_seq);
      rx_idle_flag_q <= (rx_st_q == UHD_R_IDLE) & ~(rx_run & fall);
      rx_data_ready_q  <= fifo_cnt_d >= trig_lvl;
      tx_done_flag_q <= tx_done_flag_d;
      tx_buffer_empty_q  <= ~tbuf_v_q | tx_en_rise;
      addr_q  <= addr_hit | (addr_q & ~data_rd);
      if (stat_rd) begin
        arm_q <= 1'b1;
      end else if (data_rd | data_wr) begin
        arm_q <= 1'b0;
      end
    end
  end

  // ---------------- Register port ----------------
  wire [7:0] status_v = {parity_error_flag_q, nf_q, framing_fault_flag_q, overrun_flag_q, rx_idle_flag_q, rx_data_ready_q, tx_done_flag_q, tx_buffer_empty_q};
  wire [7:0] ctrl_a_v = {ctrl_a_q[7:2], fifo_head[8], 1'b0};
  wire [7:0] rd_mux   = sel_stat ? status_v :
                        sel_ca   ? ctrl_a_v :
                        sel_cb   ? ctrl_b_q :
                        sel_cc   ? {6'h00, ctrl_c_q[1:0]} :
                        sel_data ? fifo_head[7:0] :
                        sel_dh   ? div_hi_q :
                        sel_dl   ? div_lo_q :
                        sel_fc   ? {2'b00, fifo_ctrl_q[5:0]} :
                        sel_cnt  ? {5'h00, fifo_cnt_q} : 8'h00;

  // Control register writes; status index has no write path
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_a_q    <= `UHD_RST_CTRL;
      ctrl_b_q    <= `UHD_RST_CTRL;
      ctrl_c_q    <= `UHD_RST_CTRL;
      div_hi_q    <= `UHD_RST_CTRL;
      div_lo_q    <= `UHD_RST_DIV_LOW;
      fifo_ctrl_q <= `UHD_RST_CTRL;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i) begin
        if (sel_ca) begin
          ctrl_a_q <= reg_wdata_i;
        end else if (sel_cb) begin
          ctrl_b_q <= reg_wdata_i;
        end else if (sel_cc) begin
          ctrl_c_q <= {6'h00, reg_wdata_i[1:0]};
        end else if (sel_dh) begin
          div_hi_q <= reg_wdata_i;
        end else if (sel_dl) begin
          div_lo_q <= reg_wdata_i;
        end else if (sel_fc) begin
          fifo_ctrl_q <= {2'b00, reg_wdata_i[5:0]};
        end
      end
      if (reg_rd_i) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

  // ---------------- Pins, interrupt, wake ----------------
  wire irq_d = (ctrl_b_q[`UHD_B_RX_IE] & (rx_data_ready_q | overrun_flag_q | addr_q)) |
               (ctrl_b_q[`UHD_B_TX_IDLE_IE] & tx_done_flag_q) |
               (ctrl_b_q[`UHD_B_TX_EMPTY_IE] & tx_buffer_empty_q);

  // Registered pin and event outputs
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rxtx_pin_o       <= 1'b1;
      rxtx_pin_oe_o    <= 1'b0;
      tx_pin_o         <= 1'b1;
      tx_pin_oe_o      <= 1'b0;
      tx_pullup_en_o   <= 1'b0;
      rxtx_pullup_en_o <= 1'b0;
      irq_o            <= 1'b0;
      wake_o           <= 1'b0;
    end else begin
      rxtx_pin_o       <= tline_q;
      rxtx_pin_oe_o    <= sw_drive;
      tx_pin_o         <= tline_q;
      tx_pin_oe_o      <= tx_drive;
      tx_pullup_en_o   <= gpio_pu_tx_i & ~tx_drive;
      rxtx_pullup_en_o <= gpio_pu_rxtx_i & ~sw_drive;
      irq_o            <= irq_d;
      wake_o           <= ctrl_b_q[`UHD_B_WAKE_EN] & rx_run & fall;
    end
  end
endmodule

// ==== design/uhd_map.svh ====
// Register indices, field positions, reset values and timing constants of the serial transceiver
// Overview of operation
// - Frames carry eight or nine data bits
// - Parity even, odd, mark, space or none
// - One or two stop bits per frame
// - Sixteen-bit prescaler times every transmit/receive bit
// - Address mode interrupts when last bit is one
// - Four-character receive FIFO, one-character transmit buffer
// - Interrupts: empty, idle, trigger level, overrun, address
// - Receive pin activity wakes the device
// - Enabled pins drive/receive, transmit pull-up disconnected
// - Disabled pins float, GPIO pull-up setting decides
// - Single-wire select shares one pin half-duplex
// - Single-wire: receive enable receives, else transmit
// - Both enables in single-wire: receive wins
// - Single-wire transmit may also drive transmit pin
// - Written character shifts out LSB first
// - Received bits shift in LSB first, then buffer
// - One data address: write transmits, read receives
// - Status flags are read-only, writes ignored
// - Parity mismatch sets parity flag when enabled
// - Noise flag with data flag, not on overrun
// - Bad stop bit sets framing flag
// - Status read then data access clears errors
// - Overrun flag blocks further receive transfers
// - Receiver idle low from start to stop
// - Transmitter idle when buffer empty, nothing sending
// - Enabling transmitter sets buffer-empty flag immediately
`ifndef UHD_MAP_SVH
`define UHD_MAP_SVH

// Register indices on the byte register port
`define UHD_IDX_STATUS_FLAGS   4'h0
`define UHD_IDX_UART_CTRL_A    4'h1
`define UHD_IDX_UART_CTRL_B    4'h2
`define UHD_IDX_UART_CTRL_C    4'h3
`define UHD_IDX_DATA_PORT      4'h4
`define UHD_IDX_BAUD_DIV_HIGH  4'h5
`define UHD_IDX_BAUD_DIV_LOW   4'h6
`define UHD_IDX_FIFO_CTRL      4'h7
`define UHD_IDX_RX_FILL_COUNT  4'h8

// Control field positions
`define UHD_A_SERIAL_ON   7
`define UHD_A_NINE_BIT    6
`define UHD_A_PARITY_EN   5
`define UHD_A_PARITY_HI   4
`define UHD_A_PARITY_LO   3
`define UHD_A_TX_BREAK    2
`define UHD_A_RX_BIT8     1
`define UHD_A_TX_BIT8     0
`define UHD_B_TX_ENABLE   7
`define UHD_B_RX_ENABLE   6
`define UHD_B_TWO_STOP    5
`define UHD_B_ADDR_EN     4
`define UHD_B_WAKE_EN     3
`define UHD_B_RX_IE       2
`define UHD_B_TX_IDLE_IE  1
`define UHD_B_TX_EMPTY_IE 0
`define UHD_C_TX_MIRROR   1
`define UHD_C_SINGLE_WIRE 0

// Reset values
`define UHD_RST_STATUS    8'h0b
`define UHD_RST_CTRL      8'h00
`define UHD_RST_DIV_LOW   8'h01

// Break length in bit times
`define UHD_BREAK_BITS    4'hd

`endif

// ==== design/uhd_pkg.sv ====
// Types shared by the serial transceiver
package uhd_pkg;
  typedef enum logic [2:0] {UHD_T_IDLE, UHD_T_START, UHD_T_DATA, UHD_T_PAR, UHD_T_STOP,
                            UHD_T_BREAK} uhd_tx_state_t;
  typedef enum logic [2:0] {UHD_R_IDLE, UHD_R_START, UHD_R_DATA, UHD_R_PAR,
                            UHD_R_STOP} uhd_rx_state_t;
  typedef logic [8:0] uhd_char_t;
endpackage

// ==== tb/uhd_chk.sv ====
// Port-level assertions for the serial transceiver
`timescale 1ns/100ps
module uhd_chk (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       rxtx_pin_i,
  input wire logic       rxtx_pin_o,
  input wire logic       rxtx_pin_oe_o,
  input wire logic       tx_pin_o,
  input wire logic       tx_pin_oe_o,
  input wire logic       gpio_pu_tx_i,
  input wire logic       gpio_pu_rxtx_i,
  input wire logic       tx_pullup_en_o,
  input wire logic       rxtx_pullup_en_o,
  input wire logic       irq_o,
  input wire logic       wake_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // A driven pin never keeps its pull-up
  chk_tx_pu_off: assert property (
    $past(tx_pin_oe_o, 2) && $past(tx_pin_oe_o) && tx_pin_oe_o |-> !tx_pullup_en_o)
    else $error("tx pull-up on while driving");
  chk_rxtx_pu_off: assert property (
    $past(rxtx_pin_oe_o, 2) && $past(rxtx_pin_oe_o) && rxtx_pin_oe_o |-> !rxtx_pullup_en_o)
    else $error("shared pull-up on while driving");
  // A floating pin follows the pull-up setting
  chk_tx_pu_float: assert property (
    !$past(sys_rst_i) && !$past(tx_pin_oe_o, 2) && !$past(tx_pin_oe_o) && !tx_pin_oe_o
    && $stable(gpio_pu_tx_i) |-> tx_pullup_en_o == gpio_pu_tx_i)
    else $error("tx pull-up wrong while floating");
  // Wake is a single pulse caused by a low line
  chk_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake pulse too long");
  chk_wake_cause: assert property (
    wake_o |-> !$past(rxtx_pin_i, 2) || !$past(rxtx_pin_i, 3) || !$past(rxtx_pin_i, 4))
    else $error("wake without line activity");
  // Read data holds between reads
  chk_rd_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without read");
  chk_unmapped_zero: assert property (
    reg_rd_i && reg_sel_i > 4'h8 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_fill_max: assert property (
    reg_rd_i && reg_sel_i == 4'h8 |=> reg_rdata_o <= 8'h04)
    else $error("fill count above four");

  cover property (wake_o);
  cover property ($rose(rxtx_pin_oe_o));
  cover property (reg_wr_i && reg_sel_i == 4'h4);
endmodule

bind uhd_uart uhd_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .rxtx_pin_i(rxtx_pin_i), .rxtx_pin_o(rxtx_pin_o),
  .rxtx_pin_oe_o(rxtx_pin_oe_o), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(tx_pin_oe_o),
  .gpio_pu_tx_i(gpio_pu_tx_i), .gpio_pu_rxtx_i(gpio_pu_rxtx_i),
  .tx_pullup_en_o(tx_pullup_en_o), .rxtx_pullup_en_o(rxtx_pullup_en_o),
  .irq_o(irq_o), .wake_o(wake_o));

// ==== tb/uhd_peer.sv ====
// Far-end serial device: drives frames onto the shared line and captures frames
`timescale 1ns/100ps
module uhd_peer #(
  parameter int DIV = 8          // Bit period in clocks
) (
  input  wire logic clk_i,       // System clock
  input  wire logic rxtx_line_i, // Resolved shared line
  input  wire logic tx_line_i,   // Resolved transmit line
  output logic      drv_o,       // Value driven on the shared line
  output logic      drv_oe_o     // High while driving the shared line
);
  // Line released until a frame is sent
  initial begin
    drv_o = 1'b1;
    drv_oe_o = 1'b0;
  end

  // Drives n bits LSB first, DIV clocks each, then releases the line
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      drv_oe_o <= 1'b1;
      drv_o <= f[i];
      repeat (DIV - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    drv_oe_o <= 1'b0;
  endtask

  // Samples eight data bits at mid-bit after a start edge
  task automatic recv(input logic s, output logic [7:0] d);
    wait ((s ? tx_line_i : rxtx_line_i) === 1'b0);
    repeat (DIV / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk_i);
      d[i] = s ? tx_line_i : rxtx_line_i;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial transceiver
`timescale 1ns/100ps
module testbench;
  localparam int D = 8;        // Bit period in clocks
  logic       clk_i = 1'b0;    // System clock
  logic       sys_rst_i = 1'b1; // Reset, held at start
  logic [3:0] sel = 4'h0;      // Register index
  logic [7:0] wd = 8'h00;      // Write data
  logic       reg_wr = 1'b0;   // Write strobe
  logic       reg_rd = 1'b0;   // Read strobe
  logic       pu_tx = 1'b1;    // Pull-up setting, both pins
  logic       tgl = 1'b0;      // Pattern on a floating line
  logic       woke = 1'b0;     // Wake pulse seen
  logic [7:0] rdata, v, v2;    // Read data, captured characters
  logic       rx_o, rx_oe, tx_o, tx_oe, tx_pu, rx_pu, irq, wake, p_o, p_oe;
  wire        rx_line, tx_line; // Resolved pin levels
  int         error_cnt = 0, checks = 0, cyc = 0;
  // Register rows {write, index, data or expected read}
  logic [12:0] rows [12] = '{13'h000b, 13'h10ff, 13'h000b, 13'h0601, 13'h155a, 13'h055a,
                             13'h1500, 13'h1608, 13'h1955, 13'h0900, 13'h0800, 13'h0200};

  uhd_uart dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_sel_i(sel), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .rxtx_pin_i(rx_line),
    .rxtx_pin_o(rx_o), .rxtx_pin_oe_o(rx_oe), .tx_pin_o(tx_o), .tx_pin_oe_o(tx_oe),
    .gpio_pu_tx_i(pu_tx), .gpio_pu_rxtx_i(pu_tx), .tx_pullup_en_o(tx_pu),
    .rxtx_pullup_en_o(rx_pu), .irq_o(irq), .wake_o(wake));
  uhd_peer #(.DIV(D)) peer (.clk_i(clk_i), .rxtx_line_i(rx_line), .tx_line_i(tx_line),
    .drv_o(p_o), .drv_oe_o(p_oe));

  // Pin levels from all drivers; undriven, unpulled lines wander
  assign rx_line = rx_oe ? rx_o : p_oe ? p_o : rx_pu ? 1'b1 : tgl;
  assign tx_line = tx_oe ? tx_o : tx_pu ? 1'b1 : tgl;
  always #2 clk_i = ~clk_i;
  // Pattern, wake record and hang guard
  always @(posedge clk_i) begin
    tgl <= ~tgl;
    woke <= woke | (wake === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_i);
    sel <= s;
    wd <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask
  // Reads a register and compares the masked value
  task automatic rdc(input logic [3:0] s, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    sel <= s;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, read-only status, divisor bytes, unmapped index
    foreach (rows[i]) begin
      if (rows[i][12]) wr(rows[i][11:8], rows[i][7:0]);
      else rdc(rows[i][11:8], 8'hff, rows[i][7:0]);
    end
    wr(4'h1, 8'h80);
    // A character written while disabled is dropped when the transmitter is enabled
    wr(4'h4, 8'h11);
    rdc(4'h0, 8'h01, 8'h00);
    wr(4'h2, 8'hcc);
    rdc(4'h0, 8'h01, 8'h01);
    // Transmit one character, busy while shifting
    fork
      peer.recv(1'b1, v2);
      begin
        wr(4'h4, 8'ha5);
        rdc(4'h0, 8'h02, 8'h00);
      end
    join
    chk(v2, 8'ha5);
    tick(3 * D);
    rdc(4'h0, 8'h03, 8'h03);
    // Five characters into a four-deep FIFO
    for (int i = 0; i < 5; i++) peer.send({3'b111, 8'h31 + i[7:0], 1'b0}, 10);
    rdc(4'h8, 8'hff, 8'h04);
    chk({7'h0, irq}, 8'h01);
    chk({7'h0, woke}, 8'h01);
    rdc(4'h0, 8'h10, 8'h10);
    for (int i = 0; i < 4; i++) rdc(4'h4, 8'hff, 8'h31 + i[7:0]);
    rdc(4'h0, 8'hff, 8'h0b);
    chk({7'h0, irq}, 8'h00);
    // Stop bit low; receiver busy mid-frame
    fork
      peer.send(12'h0ee, 10);
      begin
        tick(4 * D);
        rdc(4'h0, 8'h08, 8'h00);
      end
    join
    rdc(4'h0, 8'h20, 8'h20);
    rdc(4'h4, 8'hff, 8'h77);
    rdc(4'h8, 8'hff, 8'h00);
    rdc(4'h0, 8'h20, 8'h00);
    // Every parity type, right and wrong parity bit
    for (int t = 0; t < 8; t++) begin
      wr(4'h1, {3'b101, t[2:1], 3'b000});
      peer.send({2'b11, t[0], 8'h03, 1'b0}, 11);
      rdc(4'h0, 8'h80, {t[0] ^ t[2] ^ t[1], 7'h0});
      rdc(4'h4, 8'hff, 8'h03);
    end
    // Nine data bits, ninth bit one: address event alone raises irq below trigger two
    wr(4'h1, 8'hc0);
    wr(4'h7, 8'h01);
    wr(4'h2, 8'hd4);
    peer.send({2'b11, 9'h1a5, 1'b0}, 11);
    rdc(4'h1, 8'hff, 8'hc2);
    chk({7'h0, irq}, 8'h01);
    rdc(4'h4, 8'hff, 8'ha5);
    // Single wire transmit, mirrored onto the transmit pin
    wr(4'h1, 8'h80);
    wr(4'h2, 8'h80);
    wr(4'h3, 8'h03);
    fork
      peer.recv(1'b0, v);
      peer.recv(1'b1, v2);
      wr(4'h4, 8'h3c);
    join
    chk(v, 8'h3c);
    chk(v2, 8'h3c);
    tick(3 * D);
    wr(4'h2, 8'hc0);
    wr(4'h4, 8'h99);
    tick(4);
    chk({7'h0, rx_oe}, 8'h00);
    // Switched off: pins float, pull-ups follow the setting
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    pu_tx <= 1'b0;
    tick(3);
    chk({4'h0, tx_oe, tx_pu, rx_oe, rx_pu}, 8'h00);
    @(posedge clk_i);
    pu_tx <= 1'b1;
    tick(3);
    chk({4'h0, tx_oe, tx_pu, rx_oe, rx_pu}, 8'h05);
    wrap_up();
  end
endmodule
